// ==== src/sbrg_map.svh ====
// Purpose: Register offsets, field positions, reset values and counts for the rate generator
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Included by bare name
`ifndef SBRG_MAP_SVH
`define SBRG_MAP_SVH
`define SBRG_RATE_SEL_OFFSET 12'h000
`define SBRG_STATUS_OFFSET 12'h004
`define SBRG_DIVSR_LSB 0
`define SBRG_DIVSR_MSB 2
`define SBRG_PRESC_LSB 4
`define SBRG_PRESC_MSB 5
`define SBRG_RATE_SEL_RESET 8'h00
`define SBRG_FIXED_DIV 64
`define SBRG_PRE_DIV_1 4'h1
`define SBRG_PRE_DIV_3 4'h3
`define SBRG_PRE_DIV_4 4'h4
`define SBRG_PRE_DIV_13 4'hD
`endif

// ==== src/sbrg_pkg.sv ====
// Purpose: Types for the serial rate generator
// Assumes: Nothing beyond the map header
// Notes: Prescale encodings as the field stores them
package sbrg_pkg;
  typedef enum logic [1:0] {
    SBRG_PRE_1 = 2'b00,
    SBRG_PRE_3 = 2'b01,
    SBRG_PRE_4 = 2'b10,
    SBRG_PRE_13 = 2'b11
  } sbrg_presc_e;
  typedef logic [2:0] sbrg_divsr_t;
endpackage

// ==== src/sbrg_rate_gen.sv ====
// Purpose: Serial bit rate generator with APB register access
//   Divides the clock by a fixed stage, a prescale and a power of two
// Assumes: One 20 MHz clock, synchronous active-high reset
//   The APB master holds each request until it sees pready high
// Notes: One tick per bit time feeds both receiver and transmitter
//   Any write to the rate select word restarts the chain from zero
//   The status word shows the prescale and divisor counters and is read only
`timescale 1ns/10ps
`include "sbrg_map.svh"

// How it works
// - One rate setting drives a single tick shared by receiver and transmitter.
// - Two-bit prescale field picks divide by 1, 3, 4 or 13, read/write.
// - Three-bit rate divisor field divides by two to the field value, read/write.
// - Bit rate is clock over 64 times prescale value times rate divisor.
// - Reset clears both fields, giving the fastest rate.
module sbrg_rate_gen
#(
  parameter int FIXED_DIV = `SBRG_FIXED_DIV
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Rate tick to receiver and transmitter
  output logic rate_tick_o
);

  // Fixed stage counter width; FIXED_DIV must be 2 or more, not necessarily a power of two
  localparam int FW = $clog2(FIXED_DIV);

  // Configuration fields
  logic [1:0] presc_q, presc_d;
  logic [2:0] divsr_q, divsr_d;

  // Decoded divisions of the two fields
  logic [3:0] prescale_value;
  logic [7:0] rate_divisor_value;

  // Chain counters and terminal counts
  logic [FW-1:0] fix_cnt;
  logic [3:0] pre_cnt;
  logic [6:0] div_cnt;
  logic [3:0] pre_last;
  logic [6:0] div_last;

  // Stage ends, each a one-cycle enable for the next stage
  logic fix_end;
  logic pre_end;
  logic div_end;

  // Rate tick register
  logic tick_q, tick_d;

  // Bus answer registers
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;

  // Bus decode and read mux
  logic setup;
  logic wr_cfg;
  logic [31:0] rd_word;
  logic rd_err;

  // Prescale lookup from field
  always_comb
  begin
    unique case (sbrg_pkg::sbrg_presc_e'(presc_q))
      sbrg_pkg::SBRG_PRE_1: prescale_value = `SBRG_PRE_DIV_1;
      sbrg_pkg::SBRG_PRE_3: prescale_value = `SBRG_PRE_DIV_3;
      sbrg_pkg::SBRG_PRE_4: prescale_value = `SBRG_PRE_DIV_4;
      sbrg_pkg::SBRG_PRE_13: prescale_value = `SBRG_PRE_DIV_13;
    endcase
  end

  // Divisor is a power of two
  assign rate_divisor_value = 8'h01 << divsr_q;

  // Terminal counts; both fit their counters for every field code
  assign pre_last = prescale_value - 4'h1;
  assign div_last = 7'(rate_divisor_value - 8'h01);

  // Access decode; pready answers in the first access cycle, never a wait state
  assign setup = psel_i && !penable_i;
  assign wr_cfg = psel_i && penable_i && pwrite_i && (paddr_i == `SBRG_RATE_SEL_OFFSET);

  // Field next state; a refused address leaves the fields alone
  always_comb
  begin
    presc_d = presc_q;
    divsr_d = divsr_q;
    if (wr_cfg)
    begin
      presc_d = pwdata_i[`SBRG_PRESC_MSB:`SBRG_PRESC_LSB];
      divsr_d = pwdata_i[`SBRG_DIVSR_MSB:`SBRG_DIVSR_LSB];
    end
  end

  // Field registers; a single setting serves receiver and transmitter
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      presc_q <= 2'(`SBRG_RATE_SEL_RESET >> `SBRG_PRESC_LSB);
      divsr_q <= 3'(`SBRG_RATE_SEL_RESET >> `SBRG_DIVSR_LSB);
    end
    else
    begin
      presc_q <= presc_d;
      divsr_q <= divsr_d;
    end
  end

  // Read mux; bits outside the fields read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (paddr_i)
      `SBRG_RATE_SEL_OFFSET:
      begin
        rd_word[`SBRG_PRESC_MSB:`SBRG_PRESC_LSB] = presc_q;
        rd_word[`SBRG_DIVSR_MSB:`SBRG_DIVSR_LSB] = divsr_q;
      end
      `SBRG_STATUS_OFFSET:
      begin
        // Counters only; the fixed stage stays hidden
        rd_word[6:0] = div_cnt;
        rd_word[11:8] = pre_cnt;
      end
      default: rd_err = 1'b1; // Unmapped address
    endcase
  end

  // Bus answer next state; only a setup cycle launches an answer
  always_comb
  begin
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (setup)
    begin
      pready_d = 1'b1;
      prdata_d = rd_word;
      pslverr_d = rd_err;
    end
  end

  // Bus answer registers; read data holds until the next setup
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Fixed stage; runs every clock and wraps once per FIXED_DIV clocks
  sbrg_div_stage
  #(
    .WIDTH(FW)
  )
  fix_stage_inst
  (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(wr_cfg),
    .step_i(1'b1),
    .last_i(FW'(FIXED_DIV - 1)),
    .count_o(fix_cnt),
    .wrap_o(fix_end)
  );

  // Prescale stage; steps once per fixed stage wrap
  sbrg_div_stage
  #(
    .WIDTH(4)
  )
  pre_stage_inst
  (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(wr_cfg),
    .step_i(fix_end),
    .last_i(pre_last),
    .count_o(pre_cnt),
    .wrap_o(pre_end)
  );

  // Divisor stage; its wrap marks the end of a bit time
  sbrg_div_stage
  #(
    .WIDTH(7)
  )
  div_stage_inst
  (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .restart_i(wr_cfg),
    .step_i(pre_end),
    .last_i(div_last),
    .count_o(div_cnt),
    .wrap_o(div_end)
  );

  // Tick next state; a write cancels a tick due in the same cycle
  always_comb
  begin
    tick_d = div_end;
    if (wr_cfg)
    begin
      tick_d = 1'b0;
    end
  end

  // Tick register; a one-cycle pulse per bit time for both directions
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= tick_d;
    end
  end

  // Outputs straight from flip-flops
  assign prdata_o = prdata_q;
  assign pready_o = pready_q;
  assign pslverr_o = pslverr_q;
  assign rate_tick_o = tick_q;

endmodule // sbrg_rate_gen

// Counter stage of the divider chain; one copy per stage
// Restart wins over a step, so a write always lands on a clean zero
// The wrap pulse is combinational: the next stage steps in the same cycle,
// which keeps the whole chain period an exact product of the stage counts
module sbrg_div_stage
#(
  parameter int WIDTH = 4
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Chain control
  input wire logic restart_i,
  input wire logic step_i,
  input wire logic [WIDTH-1:0] last_i,
  // Count and wrap pulse
  output logic [WIDTH-1:0] count_o,
  output logic wrap_o
);

  // Stage counter
  logic [WIDTH-1:0] count_q, count_d;

  // Wrap on a step taken at the terminal count
  assign wrap_o = step_i && (count_q == last_i);

  // Counter next state
  always_comb
  begin
    count_d = count_q;
    if (step_i)
    begin
      count_d = wrap_o ? '0 : count_q + WIDTH'(1);
    end
    if (restart_i)
    begin
      count_d = '0;
    end
  end

  // Counter register
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  // Count, seen by the status word for the prescale and divisor stages only
  assign count_o = count_q;

endmodule // sbrg_div_stage

// ==== verification/sbrg_rate_gen_checker.sv ====
// Purpose: Port checks for the rate generator
// Assumes: Bench sets FIXED_DIV to 4, so ticks are 4 or more cycles apart
// Notes: Bound from the testbench top
`timescale 1ns/10ps
`include "sbrg_map.svh"
module sbrg_rate_gen_checker
#(
  parameter int FIXED_DIV = 4
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // APB side
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Rate tick
  input wire logic rate_tick_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Cycles since the last tick, config write or reset
  logic [15:0] gap_q;
  logic cfg_wr;
  assign cfg_wr = psel_i && penable_i && pwrite_i && paddr_i == `SBRG_RATE_SEL_OFFSET;
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i || rate_tick_o || cfg_wr)
      gap_q <= 16'h0000;
    else if (gap_q != 16'hFFFF)
      gap_q <= gap_q + 16'h0001;
  end
  // Bus answers and field masks
  a_ready_once: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("pready timing wrong");
  a_unmapped_err: assert property (pready_o |-> pslverr_o ==
      (paddr_i != `SBRG_RATE_SEL_OFFSET && paddr_i != `SBRG_STATUS_OFFSET))
    else $error("pslverr wrong");
  a_err_rdzero: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0000_0000)
    else $error("refused read not zero");
  a_rdback_mask: assert property (pready_o && paddr_i == `SBRG_RATE_SEL_OFFSET |->
      prdata_o[31:6] == 26'h000_0000 && !prdata_o[3])
    else $error("unused bit set");
  // Tick shape, restart and reset
  a_tick_gap: assert property (rate_tick_o |=> !rate_tick_o[*3])
    else $error("tick gap short");
  a_tick_min: assert property (rate_tick_o |-> gap_q >= 16'(FIXED_DIV - 1))
    else $error("tick period below fixed division");
  a_write_restart: assert property (cfg_wr |=> !rate_tick_o[*3])
    else $error("tick after write too soon");
  a_reset_quiet: assert property ($fell(sys_rst_i) |-> !rate_tick_o && !pready_o)
    else $error("outputs live at reset");
  c_tick: cover property (rate_tick_o);
  c_err: cover property (pslverr_o);
  c_wr: cover property (pready_o && pwrite_i);
  c_status: cover property (pready_o && paddr_i == `SBRG_STATUS_OFFSET);
endmodule // sbrg_rate_gen_checker

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the rate generator
// Assumes: FIXED_DIV cut to 4 to keep runs short
// Notes: Periods measured tick to tick
`timescale 1ns/10ps
module testbench;
  logic sys_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, rate_tick_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic er;
  int error_cnt = 0, num_checks = 0, n, d;
  sbrg_rate_gen #(.FIXED_DIV(4)) sbrg_rate_gen_inst (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rate_tick_o(rate_tick_o));
  // Clock and hang guard
  initial
  begin
    sys_clk_i = 0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    #3_000_000;
    error_cnt++;
    results;
  end
  task automatic results;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until pready seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1 && ++n < 50);
    if (n == 50)
      error_cnt++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    // Idle edge so the next call never re-drives psel in this time step
    @(posedge sys_clk_i);
  endtask
  task automatic period(input int e);
    n = 0;
    while (rate_tick_o !== 1'b1 && ++n < 20000) @(posedge sys_clk_i);
    n = 0;
    do @(posedge sys_clk_i); while (rate_tick_o !== 1'b1 && ++n < 20000);
    chk("tick period", e, n + 1);
  endtask
  function automatic int pd(input int p);
    return p == 0 ? 1 : p == 1 ? 3 : p == 2 ? 4 : 13;
  endfunction
  initial
  begin
    {sys_rst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {1'b1, 47'h0};
    void'($urandom(32'h1c83));
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    apb(0, 12'h000, 0);
    chk("reset value", 0, rd);
    period(4);
    // Every prescale code, random divisor (7 for code 3), junk in unused bits
    for (int p = 0; p < 4; p++)
    begin
      d = (p == 3) ? 7 : $urandom % 8;
      apb(1, 12'h000, ($urandom & 32'hFFFF_FFC8) | (p << 4) | d);
      apb(0, 12'h000, 0);
      chk("rate select", (p << 4) | d, rd);
      period(4 * pd(p) * (1 << d));
    end
    // Just after a tick every chain counter has wrapped to zero
    apb(0, 12'h004, 0);
    chk("status after tick", 0, rd);
    chk("mapped read error", 0, er);
    apb(1, 12'h008, 32'hFFFF_FFFF);
    chk("unmapped error", 1, er);
    apb(0, 12'h000, 0);
    chk("after refused write", 32'h0000_0037, rd);
    results;
  end
endmodule // testbench
bind sbrg_rate_gen sbrg_rate_gen_checker #(.FIXED_DIV(FIXED_DIV)) sbrg_rate_gen_checker_inst (
  .sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .rate_tick_o(rate_tick_o));
